// *** inc/tlps_pkg.sv ***
// Package of constants for the tributary line port sampling block.
`default_nettype none
package tlps_pkg;
   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0] TLPS_REG_MODE = 8'h00;
   localparam logic [7:0] TLPS_REG_IN_EDGE = 8'h04;
   localparam logic [7:0] TLPS_REG_OUT_EDGE = 8'h08;
   localparam logic [7:0] TLPS_REG_STATUS = 8'h0C;
   localparam logic [7:0] TLPS_REG_TX_WORD = 8'h10;
   localparam logic [7:0] TLPS_REG_RX_WORD = 8'h14;
   localparam logic [7:0] TLPS_REG_LINE_PRI = 8'h18;
   localparam logic [7:0] TLPS_REG_LINE_RED = 8'h1C;
   // Reset values of the configuration registers.
   localparam logic [31:0] TLPS_RST_CFG = 32'h0000_0000;
   // Field positions in the TX word register.
   localparam int TLPS_CH_LSB = 8;
   localparam int TLPS_NEG_BIT = 1;
   localparam int TLPS_DATA_BIT = 0;
   // AXI responses.
   localparam logic [1:0] TLPS_RESP_OKAY = 2'h0;
   localparam logic [1:0] TLPS_RESP_SLVERR = 2'h2;
   // Channel operating modes.
   typedef enum logic [0:0]
   {
      TLPS_MODE_DS3E3 = 1'b0,
      TLPS_MODE_STS1 = 1'b1
   } tlps_mode_t;
endpackage : tlps_pkg
`default_nettype wire

// *** verilog/tlps_fifo.sv ***
// Small flip-flop FIFO with valid and ready on both sides.
`default_nettype none
module tlps_fifo
   import tlps_pkg::*;
#(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
)
(
   // Clock and control.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   wire push = in_valid && in_ready && ce;
   wire pop = out_valid && out_ready && ce;

   // Full and empty come straight from the fill count.
   assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];

   // Pointer and count update.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_ff[wr_ff] <= in_data;
            wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop)
            rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         if (push && !pop)
            cnt_ff <= cnt_ff + 1'b1;
         else if (pop && !push)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule // tlps_fifo
`default_nettype wire

// *** verilog/tlps_top.sv ***
// Tributary and high-speed line port sampling block with AXI4-Lite registers.
// How it works
// - Each high-speed receive line port captures its data on every rising edge of its forwarded line clock while ce is high.
// - A primary and a redundant line port exist and both capture data in the same way.
// - In DS3/E3 mode a channel samples both the data and the negative rail on the configured clock edge.
// - In STS-1 mode a channel samples only the data input and ignores the negative rail.
// - In STS-1 mode the ingress data is sampled on the rising or falling ingress clock edge as configured.
// - In DS3/E3 mode egress data and negative rail change on the configured egress clock edge.
// - In STS-1 mode all egress data leaves on the data output and the negative rail stays low.
// - In STS-1 mode the egress data output changes on the configured egress clock edge.
`default_nettype none
module tlps_top
   import tlps_pkg::*;
#(
   parameter int NCH = 3,
   parameter int FIFO_DEPTH = 4
)
(
   // Clock, reset and enable.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write address and data.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // High-speed line ports, primary and redundant.
   input wire logic [1:0] line_rx_data_pos,
   input wire logic [1:0] line_rx_clock_pos,
   // Tributary ingress pins per channel.
   input wire logic [NCH-1:0] trib_ingress_data,
   input wire logic [NCH-1:0] trib_ingress_neg_rail,
   input wire logic [NCH-1:0] trib_ingress_clock,
   // Tributary egress pins per channel.
   input wire logic [NCH-1:0] trib_egress_clock,
   output logic [NCH-1:0] trib_egress_data,
   output logic [NCH-1:0] trib_egress_neg_rail
);
   // Assertions without a clock of their own use the bus clock and reset.
   default clocking assert_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Per-channel configuration and sampled state.
   logic [NCH-1:0] mode_ff;
   logic [NCH-1:0] nxt_mode;
   logic [NCH-1:0] in_fall_ff;
   logic [NCH-1:0] out_fall_ff;
   logic [NCH-1:0] in_pos_ff;
   logic [NCH-1:0] in_neg_ff;
   logic [NCH-1:0] in_hit_ff;
   logic [NCH-1:0] out_data_ff;
   logic [NCH-1:0] out_neg_ff;
   logic [NCH-1:0] out_hit_ff;
   logic [31:0] line_pri_ff;
   logic [31:0] line_red_ff;

   // Two-stage synchronisers for every pin input.
   logic [NCH-1:0] id_s1, id_s2, in_s1, in_s2, ic_s1, ic_s2, ic_d;
   logic [NCH-1:0] oc_s1, oc_s2, oc_d;
   logic [1:0] ld_s1, ld_s2, lc_s1, lc_s2, lc_d;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {id_s1, id_s2, in_s1, in_s2, ic_s1, ic_s2, ic_d} <= '0;
         {oc_s1, oc_s2, oc_d, ld_s1, ld_s2, lc_s1, lc_s2, lc_d} <= '0;
      end
      else if (ce)
      begin
         {id_s1, in_s1, ic_s1, oc_s1} <= {trib_ingress_data, trib_ingress_neg_rail,
                                         trib_ingress_clock, trib_egress_clock};
         {id_s2, in_s2, ic_s2, oc_s2} <= {id_s1, in_s1, ic_s1, oc_s1};
         {ld_s1, lc_s1} <= {line_rx_data_pos, line_rx_clock_pos};
         {ld_s2, lc_s2} <= {ld_s1, lc_s1};
         ic_d <= ic_s2;
         oc_d <= oc_s2;
         lc_d <= lc_s2;
      end
   end

   // Edge detection and per-channel edge selection.
   wire [NCH-1:0] ic_rise = ic_s2 & ~ic_d;
   wire [NCH-1:0] ic_fall = ~ic_s2 & ic_d;
   wire [NCH-1:0] oc_rise = oc_s2 & ~oc_d;
   wire [NCH-1:0] oc_fall = ~oc_s2 & oc_d;
   wire [1:0] lc_rise = lc_s2 & ~lc_d;
   wire [NCH-1:0] in_strobe = (in_fall_ff & ic_fall) | (~in_fall_ff & ic_rise);
   wire [NCH-1:0] out_strobe = (out_fall_ff & oc_fall) | (~out_fall_ff & oc_rise);

   // FIFO between software egress words and the egress launch logic.
   logic tx_valid, tx_ready, ef_valid, ef_ready;
   logic [3:0] tx_word, ef_word;
   tlps_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_word),
      .out_valid(ef_valid),
      .out_ready(ef_ready),
      .out_data(ef_word)
   );
   wire [1:0] ef_ch = ef_word[3:2];
   wire ef_ch_ok = (ef_ch < 2'(NCH));
   // A word drains only when its channel's egress edge arrives; a bad channel drops.
   assign ef_ready = ef_valid && (!ef_ch_ok || out_strobe[ef_ch]);

   // Ingress sampling, egress launch and line capture.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {in_pos_ff, in_neg_ff, out_data_ff, out_neg_ff} <= '0;
         line_pri_ff <= TLPS_RST_CFG;
         line_red_ff <= TLPS_RST_CFG;
      end
      else if (ce)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            if (nxt_mode[c] == TLPS_MODE_STS1)
            begin
               in_neg_ff[c] <= 1'b0;
               out_neg_ff[c] <= 1'b0;
            end
            if (in_strobe[c])
            begin
               in_pos_ff[c] <= id_s2[c];
               in_neg_ff[c] <= (nxt_mode[c] == TLPS_MODE_STS1) ? 1'b0 : in_s2[c];
            end
            if (ef_valid && ef_ready && ef_ch_ok && ef_ch == 2'(c))
            begin
               out_data_ff[c] <= ef_word[TLPS_DATA_BIT];
               out_neg_ff[c] <= (nxt_mode[c] == TLPS_MODE_STS1) ? 1'b0 : ef_word[TLPS_NEG_BIT];
            end
         end
         if (lc_rise[0])
            line_pri_ff <= {line_pri_ff[30:0], ld_s2[0]};
         if (lc_rise[1])
            line_red_ff <= {line_red_ff[30:0], ld_s2[1]};
      end
   end
   assign trib_egress_data = out_data_ff;
   assign trib_egress_neg_rail = out_neg_ff;

   // Sticky ingress and egress edge flags, set winning over a read clear.
   logic rd_status;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_hit_ff <= '0;
         out_hit_ff <= '0;
      end
      else if (ce)
      begin
         in_hit_ff <= in_strobe | (rd_status ? '0 : in_hit_ff);
         out_hit_ff <= out_strobe | (rd_status ? '0 : out_hit_ff);
      end
   end

   // AXI4-Lite write path: address and data held until both are present.
   logic aw_ff, w_ff, bvalid_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   wire wr_go = aw_ff && w_ff && !bvalid_ff;
   wire wr_tx = (awaddr_ff == TLPS_REG_TX_WORD);
   wire wr_known = (awaddr_ff == TLPS_REG_MODE) || (awaddr_ff == TLPS_REG_IN_EDGE) ||
                   (awaddr_ff == TLPS_REG_OUT_EDGE) || wr_tx;
   // A TX word write waits for FIFO room, stalling the response.
   wire wr_fire = wr_go && (!wr_tx || tx_ready);
   // Mode about to be stored, so a channel switched to STS-1 drops its rails in the same cycle.
   assign nxt_mode = (ce && wr_fire && wstrb_ff[0] && awaddr_ff == TLPS_REG_MODE) ?
                     wdata_ff[NCH-1:0] : mode_ff;
   assign tx_valid = wr_go && wr_tx && wstrb_ff[1] & wstrb_ff[0];
   assign tx_word = {wdata_ff[TLPS_CH_LSB+1:TLPS_CH_LSB], wdata_ff[TLPS_NEG_BIT], wdata_ff[TLPS_DATA_BIT]};
   assign s_axi_awready = ce && !aw_ff;
   assign s_axi_wready = ce && !w_ff;
   assign s_axi_bvalid = bvalid_ff;
   logic [1:0] bresp_ff;
   assign s_axi_bresp = bresp_ff;

   // Write channel state and configuration registers.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {aw_ff, w_ff, bvalid_ff} <= '0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         bresp_ff <= TLPS_RESP_OKAY;
         mode_ff <= NCH'(TLPS_RST_CFG);
         in_fall_ff <= NCH'(TLPS_RST_CFG);
         out_fall_ff <= NCH'(TLPS_RST_CFG);
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_known ? TLPS_RESP_OKAY : TLPS_RESP_SLVERR;
            if (wstrb_ff[0] && awaddr_ff == TLPS_REG_MODE)
               mode_ff <= wdata_ff[NCH-1:0];
            if (wstrb_ff[0] && awaddr_ff == TLPS_REG_IN_EDGE)
               in_fall_ff <= wdata_ff[NCH-1:0];
            if (wstrb_ff[0] && awaddr_ff == TLPS_REG_OUT_EDGE)
               out_fall_ff <= wdata_ff[NCH-1:0];
         end
         if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   // AXI4-Lite read path: one-cycle decode into registered data.
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   assign s_axi_arready = ce && !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   wire rd_take = s_axi_arvalid && s_axi_arready;
   wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
   assign rd_status = rd_take && (ra == TLPS_REG_STATUS);
   // Sticky edge flags packed into the low status byte, ingress from bit 0 and egress from bit 4.
   wire [7:0] hit_bits = (8'(out_hit_ff) << 4) | 8'(in_hit_ff);
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb
   begin
      rd_mux = '0;
      rd_ok = 1'b1;
      case (ra)
         TLPS_REG_MODE: rd_mux[NCH-1:0] = mode_ff;
         TLPS_REG_IN_EDGE: rd_mux[NCH-1:0] = in_fall_ff;
         TLPS_REG_OUT_EDGE: rd_mux[NCH-1:0] = out_fall_ff;
         TLPS_REG_STATUS: rd_mux = {16'h0000, 1'b0, ef_valid, ~tx_ready, 5'h00, hit_bits};
         TLPS_REG_RX_WORD: rd_mux = {8'h00, 8'(in_neg_ff), 8'h00, 8'(in_pos_ff)};
         TLPS_REG_LINE_PRI: rd_mux = line_pri_ff;
         TLPS_REG_LINE_RED: rd_mux = line_red_ff;
         TLPS_REG_TX_WORD: rd_mux = '0;
         default: rd_ok = 1'b0;
      endcase
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= TLPS_RESP_OKAY;
      end
      else if (ce)
      begin
         if (rd_take)
         begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_ok ? TLPS_RESP_OKAY : TLPS_RESP_SLVERR;
         end
         else if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
      end
   end

   // STS-1 channels never show a negative-rail sample or launch.
   chk_sts_neg_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      ((mode_ff & in_neg_ff) == '0)) else $error("STS-1 channel holds a negative-rail sample.");
   chk_sts_neg_out: assert property (@(posedge aclk) disable iff (!aresetn)
      ((mode_ff & trib_egress_neg_rail) == '0)) else $error("STS-1 channel drives the negative rail.");
   // Ingress sample tracks the synchronised pin one cycle after a selected edge.
   chk_in_sample: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && in_strobe[0]) |=> (in_pos_ff[0] == $past(id_s2[0]))) else $error("Ingress sample missed.");
   chk_in_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && !in_strobe[0]) |=> $stable(in_pos_ff[0])) else $error("Ingress sampled off its edge.");
   chk_out_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && !out_strobe[0]) |=> $stable(trib_egress_data[0])) else $error("Egress changed off its edge.");
   chk_out_neg_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && !out_strobe[1] && (mode_ff[1] || !nxt_mode[1])) |=> $stable(trib_egress_neg_rail[1]))
      else $error("Negative rail off its edge.");
   chk_line_pri: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && lc_rise[0]) |=> (line_pri_ff[0] == $past(ld_s2[0]))) else $error("Primary line bit lost.");
   chk_line_red: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && !lc_rise[1]) |=> $stable(line_red_ff)) else $error("Redundant line shifted off edge.");
   chk_edge_sel: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_strobe[1] && in_fall_ff[1]) |-> ic_fall[1]) else $error("Channel edge choice not honoured.");
   // Line and ingress capture take the synchronised pin value at the chosen edge only.
   chk_red_bit: assert property (
      (ce && lc_rise[1]) |=> (line_red_ff[0] == $past(ld_s2[1])))
      else $error("Redundant line bit lost.");
   chk_pri_hold: assert property (
      (ce && !lc_rise[0]) |=> $stable(line_pri_ff))
      else $error("Primary line shifted off edge.");
   chk_neg_sample: assert property (
      (ce && in_strobe[2] && !nxt_mode[2]) |=> (in_neg_ff[2] == $past(in_s2[2])))
      else $error("Negative rail sample missed.");
   chk_sts_ignore: assert property (
      (ce && in_strobe[0] && nxt_mode[0]) |=> !in_neg_ff[0])
      else $error("STS-1 channel sampled its negative rail.");
   // A drained word appears on its channel's egress pins in the next cycle.
   chk_launch_data: assert property (
      (ce && ef_ready && ef_ch == 2'h0) |=> (trib_egress_data[0] == $past(ef_word[TLPS_DATA_BIT])))
      else $error("Egress data not launched.");
   chk_launch_neg: assert property (
      (ce && ef_ready && ef_ch == 2'h2 && !nxt_mode[2]) |=> (trib_egress_neg_rail[2] == $past(ef_word[TLPS_NEG_BIT])))
      else $error("Egress negative rail not launched.");
   chk_sts_launch: assert property (
      (ce && ef_ready && ef_ch == 2'h1 && nxt_mode[1]) |=> !trib_egress_neg_rail[1])
      else $error("STS-1 launch drove the negative rail.");
endmodule // tlps_top
`default_nettype wire

// *** sim/tlps_liu_model.sv ***
// Behavioural line interface unit and transceiver model for the line and tributary pins.
`default_nettype none
module tlps_liu_model
#(
   parameter int NCH = 3
)
(
   // High-speed line ports, primary in bit 0.
   output logic [1:0] line_rx_data_pos,
   output logic [1:0] line_rx_clock_pos,
   // Tributary ingress pins.
   output logic [NCH-1:0] trib_ingress_data,
   output logic [NCH-1:0] trib_ingress_neg_rail,
   output logic [NCH-1:0] trib_ingress_clock,
   // Tributary egress clock.
   output logic [NCH-1:0] trib_egress_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam real HALF_NS = 62.5;

   // All clocks stand still and low until a frame is sent.
   initial
   begin
      line_rx_data_pos = 2'h0;
      line_rx_clock_pos = 2'h0;
      trib_ingress_data = '0;
      trib_ingress_neg_rail = '0;
      trib_ingress_clock = '0;
      trib_egress_clock = '0;
   end

   // Sends a byte first bit first; data moves on the falling edge, away from the capturing rise.
   task automatic line_byte(input int port, input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         line_rx_data_pos[port] = b[i];
         #(HALF_NS) line_rx_clock_pos[port] = 1'h1;
         #(HALF_NS) line_rx_clock_pos[port] = 1'h0;
      end
      line_rx_data_pos[port] = ~b[0];
   endtask

   // One clock pulse: values a are valid at the rise, values b at the fall, then the pins are scrambled.
   task automatic ingress_frame(input logic [NCH-1:0] a, an, b, bn);
      trib_ingress_data = a;
      trib_ingress_neg_rail = an;
      #(HALF_NS) trib_ingress_clock = '1;
      #40 trib_ingress_data = b;
      trib_ingress_neg_rail = bn;
      #(HALF_NS - 40.0) trib_ingress_clock = '0;
      #40 trib_ingress_data = ~b;
      trib_ingress_neg_rail = ~bn;
   endtask

   // Sets the egress clock levels of all channels.
   task automatic egress_level(input logic [NCH-1:0] lv);
      trib_egress_clock = lv;
   endtask
endmodule // tlps_liu_model
`default_nettype wire

// *** sim/tlps_top_bench.sv ***
// Self-checking testbench for the tributary line port sampling block.
`default_nettype none
module tlps_top_bench
   import tlps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] mask; logic [31:0] data; logic [1:0] resp;} tlps_rexp_t;
   logic aclk, aresetn, ce;
   logic [7:0] s_axi_awaddr, s_axi_araddr, seed;
   logic [31:0] s_axi_wdata, s_axi_rdata, rx;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, line_rx_data_pos, line_rx_clock_pos, w;
   logic [2:0] trib_ingress_data, trib_ingress_neg_rail, trib_ingress_clock, trib_egress_clock;
   logic [2:0] trib_egress_data, trib_egress_neg_rail, mode_v, ie_v, oe_v, a, an, b, bn;
   logic [1:0] prev [3];
   logic [1:0] fw [4];
   tlps_rexp_t rq [$];
   tlps_rexp_t rexp;
   logic [1:0] bq [$];
   int num_errors = 0;
   int checks_done = 0;

   tlps_top #(.NCH(3), .FIFO_DEPTH(4)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_rx_data_pos(line_rx_data_pos),
      .line_rx_clock_pos(line_rx_clock_pos), .trib_ingress_data(trib_ingress_data),
      .trib_ingress_neg_rail(trib_ingress_neg_rail), .trib_ingress_clock(trib_ingress_clock),
      .trib_egress_clock(trib_egress_clock), .trib_egress_data(trib_egress_data),
      .trib_egress_neg_rail(trib_egress_neg_rail));
   tlps_liu_model #(.NCH(3)) liu (.line_rx_data_pos(line_rx_data_pos), .line_rx_clock_pos(line_rx_clock_pos),
      .trib_ingress_data(trib_ingress_data), .trib_ingress_neg_rail(trib_ingress_neg_rail),
      .trib_ingress_clock(trib_ingress_clock), .trib_egress_clock(trib_egress_clock));

   // Free-running 100 MHz clock.
   initial
   begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // AXI4-Lite write; the expected response is noted for the monitor.
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      int n;
      bq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid && n < 200);
      s_axi_bready <= 1'h0;
      if (n >= 200) num_errors++;
   endtask

   // AXI4-Lite read; the masked expected data and response are noted for the monitor.
   task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
      int n;
      rq.push_back('{m, d, r});
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid && n < 200);
      s_axi_rready <= 1'h0;
      if (n >= 200) num_errors++;
   endtask

   // Writes the per-channel mode and edge choices and reads them back.
   task automatic cfg();
      wr(TLPS_REG_MODE, {29'h0, mode_v}, 4'hF, TLPS_RESP_OKAY);
      wr(TLPS_REG_IN_EDGE, {29'h0, ie_v}, 4'hF, TLPS_RESP_OKAY);
      wr(TLPS_REG_OUT_EDGE, {29'h0, oe_v}, 4'hF, TLPS_RESP_OKAY);
      rd(TLPS_REG_MODE, 32'hFFFF_FFFF, {29'h0, mode_v}, TLPS_RESP_OKAY);
      rd(TLPS_REG_IN_EDGE, 32'hFFFF_FFFF, {29'h0, ie_v}, TLPS_RESP_OKAY);
      rd(TLPS_REG_OUT_EDGE, 32'hFFFF_FFFF, {29'h0, oe_v}, TLPS_RESP_OKAY);
   endtask

   // Monitor takes the oldest note whenever a read or write answer is handed over.
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
      begin
         rexp = rq.pop_front();
         check("rdata", s_axi_rdata & rexp.mask, rexp.data);
         check("rresp", {30'h0, s_axi_rresp}, {30'h0, rexp.resp});
      end
      if (s_axi_bvalid && s_axi_bready) check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
   end

   // Watchdog cuts a hang short well beyond the expected run time.
   initial
   begin
      #100000;
      num_errors++;
      $display("Watchdog expired");
      complete_run();
   end

   // Main sequence.
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      aresetn = 1'h0;
      ce = 1'h1;
      seed = 8'h24;
      prev = '{2'h0, 2'h0, 2'h0};
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      rd(TLPS_REG_MODE, 32'hFFFF_FFFF, TLPS_RST_CFG, TLPS_RESP_OKAY);
      rd(TLPS_REG_IN_EDGE, 32'hFFFF_FFFF, TLPS_RST_CFG, TLPS_RESP_OKAY);
      rd(TLPS_REG_OUT_EDGE, 32'hFFFF_FFFF, TLPS_RST_CFG, TLPS_RESP_OKAY);
      rd(TLPS_REG_TX_WORD, 32'hFFFF_FFFF, 32'h0, TLPS_RESP_OKAY);
      rd(8'h20, 32'h0, 32'h0, TLPS_RESP_SLVERR);
      wr(8'h24, 32'h0000_0001, 4'hF, TLPS_RESP_SLVERR);
      $display("Test registers done");
      seed = lfsr_next(seed);
      liu.line_byte(0, seed);
      rx = {24'h0, seed};
      seed = lfsr_next(seed);
      liu.line_byte(1, seed);
      repeat (10) @(posedge aclk);
      rd(TLPS_REG_LINE_PRI, 32'hFFFF_FFFF, rx, TLPS_RESP_OKAY);
      rd(TLPS_REG_LINE_RED, 32'hFFFF_FFFF, {24'h0, seed}, TLPS_RESP_OKAY);
      $display("Test line ports done");
      ce <= 1'h0;
      liu.line_byte(0, 8'hA5);
      @(posedge aclk);
      ce <= 1'h1;
      rd(TLPS_REG_LINE_PRI, 32'hFFFF_FFFF, rx, TLPS_RESP_OKAY);
      $display("Test clock enable done");
      for (int k = 0; k < 2; k++)
      begin
         mode_v = k ? 3'h5 : 3'h2;
         ie_v = k ? 3'h6 : 3'h1;
         oe_v = k ? 3'h3 : 3'h4;
         cfg();
         seed = lfsr_next(seed);
         {an, a} = seed[5:0];
         seed = lfsr_next(seed);
         {bn, b} = seed[5:0];
         liu.ingress_frame(a, an, b, bn);
         repeat (20) @(posedge aclk);
         rx = 32'h0;
         for (int c = 0; c < 3; c++)
         begin
            rx[c] = ie_v[c] ? b[c] : a[c];
            rx[16+c] = mode_v[c] ? 1'h0 : (ie_v[c] ? bn[c] : an[c]);
         end
         rd(TLPS_REG_RX_WORD, 32'hFFFF_FFFF, rx, TLPS_RESP_OKAY);
         for (int c = 0; c < 3; c++)
         begin
            seed = lfsr_next(seed);
            wr(TLPS_REG_TX_WORD, {22'h0, 2'(c), 6'h0, seed[1:0]}, 4'hF, TLPS_RESP_OKAY);
            w = {mode_v[c] ? 1'h0 : seed[1], seed[0]};
            liu.egress_level(3'h1 << c);
            repeat (10) @(posedge aclk);
            check("egress at rise", {30'h0, trib_egress_neg_rail[c], trib_egress_data[c]},
                  {30'h0, oe_v[c] ? {prev[c][1] & ~mode_v[c], prev[c][0]} : w});
            liu.egress_level(3'h0);
            repeat (10) @(posedge aclk);
            check("egress at fall", {30'h0, trib_egress_neg_rail[c], trib_egress_data[c]}, {30'h0, w});
            prev[c] = w;
         end
      end
      $display("Test tributary edges done");
      mode_v = 3'h0;
      ie_v = 3'h0;
      oe_v = 3'h0;
      cfg();
      wr(TLPS_REG_TX_WORD, 32'h0000_0003, 4'h1, TLPS_RESP_OKAY);
      rd(TLPS_REG_STATUS, 32'h0000_6000, 32'h0, TLPS_RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr_next(seed);
         fw[i] = seed[1:0];
         wr(TLPS_REG_TX_WORD, {30'h0, seed[1:0]}, 4'hF, TLPS_RESP_OKAY);
      end
      rd(TLPS_REG_STATUS, 32'h0000_6077, 32'h0000_6000, TLPS_RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         liu.egress_level(3'h1);
         repeat (10) @(posedge aclk);
         check("fifo drain", {30'h0, trib_egress_neg_rail[0], trib_egress_data[0]}, {30'h0, fw[i]});
         liu.egress_level(3'h0);
         repeat (10) @(posedge aclk);
      end
      rd(TLPS_REG_STATUS, 32'h0000_6077, 32'h0000_0010, TLPS_RESP_OKAY);
      $display("Test fifo done");
      complete_run();
   end
endmodule // tlps_top_bench
`default_nettype wire
